// ### design/host_memory_port.sv
// Contract
// - Host reaches only on-chip program and data memory, never control registers.
// - Latch with bit 15 high takes bits 7..0 as overlay; 14..8 zero.
// - Latch with bit 15 low takes 13..0 as address, 14 as memory type.
// - One 16-bit multiplexed bus, still reaching 24-bit program memory.
// - Strobes need no clock reference; writes accepted at full speed.
// - Latched address increments by one after each data access, or after the second half of each program word.
// - Address and type captured on falling edge of address latch.
// - Select plus read or write: one sync cycle, one memory cycle.
// - Overlay and start address kept in two processor-visible registers.
// - Start address register at data 0x3FE0; host cannot read it back.
// - Overlay register at processor data location 0x3FE7.
// - Processor software may also write start address and memory type.
// - Boot strap C=1 B=0 A=1 at reset selects boot through port.
// - Boot hold lasts until host writes program memory location 0.
`timescale 1ns/1ps
`default_nettype none
`include "host_port_consts.svh"

module host_memory_port
  import host_port_pkg::*;
#(
  parameter int DEPTH = 16384
) (
  input wire logic mclk, // System clock, 25 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic port_select_n, // Host port select, active low.
  input wire logic port_address_latch, // Host address latch strobe.
  input wire logic port_read_n, // Host read strobe, active low.
  input wire logic port_write_n, // Host write strobe, active low.
  input wire logic [15:0] port_addr_data_bus_in, // Bus level seen.
  output logic [15:0] port_addr_data_bus_out, // Bus read data.
  output logic port_addr_data_bus_oe, // High while driving the bus.
  output logic port_acknowledge, // High when the port is ready.
  input wire logic [13:0] dsp_addr, // Processor data-space address.
  input wire logic dsp_wr, // Processor register write strobe.
  input wire logic dsp_rd, // Processor register read strobe.
  input wire logic [15:0] dsp_wdata, // Processor write data.
  output logic [15:0] dsp_rdata, // Processor read data.
  input wire logic mode_a, // Boot mode strap A.
  input wire logic mode_b, // Boot mode strap B.
  input wire logic mode_c, // Boot mode strap C.
  output logic boot_hold // High while execution is held off.
);

  mem_port_if mp ();

  onchip_memory #(.DEPTH(DEPTH)) u_mem (
    .mclk(mclk),
    .mp(mp)
  );

  port_state_e state_ff;
  logic ale_prev_ff;
  logic xfer_prev_ff;
  logic is_read_ff;
  logic half_ff;
  logic pm_sel_ff;
  logic [13:0] addr_ff;
  logic [7:0] overlay_ff;
  logic [15:0] upper_ff;
  logic [15:0] wdata_ff;
  logic strap_done_ff;
  logic [15:0] bus_out_ff;
  logic bus_oe_ff;
  logic ack_ff;
  logic [15:0] dsp_rdata_ff;
  logic boot_hold_ff;

  logic selected;
  logic xfer_req;
  logic latch_fall;
  logic xfer_start;
  logic word_done;
  logic nxt_mem_we;

  // ****************************************************************
  // Host strobe decode
  // ****************************************************************
  // The host strobes carry no clock relation, so the address latch and the
  // read or write request are each judged by their edge against the
  // sample of the previous cycle; select is taken as a level.
  assign selected = !port_select_n;
  assign xfer_req = selected && (!port_read_n || !port_write_n);
  assign latch_fall = selected && ale_prev_ff && !port_address_latch;
  assign xfer_start = xfer_req && !xfer_prev_ff && state_ff == ST_IDLE;
  // A data word ends on any data access or the second program half.
  assign word_done = state_ff == ST_ACCESS && (!pm_sel_ff || half_ff);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ale_prev_ff <= 1'b0;
      xfer_prev_ff <= 1'b0;
    end else begin
      ale_prev_ff <= selected && port_address_latch;
      xfer_prev_ff <= xfer_req;
    end
  end

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      is_read_ff <= 1'b0;
      wdata_ff <= 16'h0000;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (xfer_start) begin
            state_ff <= ST_SYNC;
            is_read_ff <= !port_read_n;
          end
        end
        ST_SYNC: begin
          wdata_ff <= port_addr_data_bus_in;
          state_ff <= ST_ACCESS;
        end
        ST_ACCESS: begin
          state_ff <= ST_DONE;
        end
        ST_DONE: begin
          if (!xfer_req) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Acknowledge falls while busy and rises once the access is over.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (state_ff == ST_IDLE && !xfer_start) ||
        state_ff == ST_DONE;
    end
  end

  // ****************************************************************
  // Memory access
  // ****************************************************************
  // The first half of a program word only fills the holding register,
  // so the 24-bit location is written whole in one cycle.
  assign nxt_mem_we = !is_read_ff && (!pm_sel_ff || half_ff);
  assign mp.req = state_ff == ST_ACCESS && (is_read_ff || nxt_mem_we);
  assign mp.we = nxt_mem_we;
  assign mp.pm = pm_sel_ff;
  assign mp.addr = addr_ff;
  assign mp.wdata = pm_sel_ff ? {upper_ff, wdata_ff[7:0]}
                              : {8'h00, wdata_ff};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      upper_ff <= 16'h0000;
    end else if (state_ff == ST_ACCESS && pm_sel_ff && !half_ff) begin
      upper_ff <= wdata_ff;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_out_ff <= 16'h0000;
      bus_oe_ff <= 1'b0;
    end else begin
      // The half pointer has already moved on when the word is shown,
      // so a set pointer means the upper half was just read.
      if (state_ff == ST_DONE && is_read_ff) begin
        bus_out_ff <= !pm_sel_ff ? mp.rdata[15:0] :
          (half_ff ? mp.rdata[23:8] : {8'h00, mp.rdata[7:0]});
      end
      bus_oe_ff <= state_ff == ST_DONE && is_read_ff && selected &&
        !port_read_n;
    end
  end

  // ****************************************************************
  // Address, memory type, half pointer and overlay registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff <= `HP_ADDR_RST;
      pm_sel_ff <= 1'b0;
      half_ff <= 1'b0;
    end else if (latch_fall &&
                 !port_addr_data_bus_in[`HP_BUS_OVL_FLAG]) begin
      addr_ff <= port_addr_data_bus_in[`HP_BUS_ADDR_MSB:0];
      pm_sel_ff <= port_addr_data_bus_in[`HP_BUS_MEM_SEL];
      half_ff <= 1'b0;
    end else if (state_ff == ST_ACCESS) begin
      half_ff <= pm_sel_ff && !half_ff;
      if (word_done) begin
        addr_ff <= addr_ff + 14'h0001;
      end
    end else if (dsp_wr && dsp_addr == `HP_START_ADDR_LOC) begin
      // A host latch in the same cycle takes priority over software.
      addr_ff <= dsp_wdata[`HP_BUS_ADDR_MSB:0];
      pm_sel_ff <= dsp_wdata[`HP_BUS_MEM_SEL];
      half_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overlay_ff <= `HP_OVL_RST;
    end else if (latch_fall &&
                 port_addr_data_bus_in[`HP_BUS_OVL_FLAG]) begin
      overlay_ff <= port_addr_data_bus_in[`HP_BUS_OVL_MSB:0];
    end else if (dsp_wr && dsp_addr == `HP_OVERLAY_LOC) begin
      overlay_ff <= dsp_wdata[`HP_BUS_OVL_MSB:0];
    end
  end

  // ****************************************************************
  // Processor register read port
  // ****************************************************************
  // Only the processor side sees these; the host bus has no path here.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dsp_rdata_ff <= 16'h0000;
    end else if (dsp_rd) begin
      if (dsp_addr == `HP_START_ADDR_LOC) begin
        dsp_rdata_ff <= {1'b0, pm_sel_ff, addr_ff};
      end else if (dsp_addr == `HP_OVERLAY_LOC) begin
        dsp_rdata_ff <= {8'h00, overlay_ff};
      end else begin
        dsp_rdata_ff <= 16'h0000;
      end
    end
  end

  // ****************************************************************
  // Boot strap and execution hold
  // ****************************************************************
  // Straps are caught by the first clock after reset release.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_ff <= 1'b0;
      boot_hold_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      boot_hold_ff <= {mode_c, mode_b, mode_a} == `HP_BOOT_MODE;
    end else if (mp.req && mp.we && mp.pm &&
                 mp.addr == `HP_BOOT_LOC) begin
      boot_hold_ff <= 1'b0;
    end
  end

  assign port_addr_data_bus_out = bus_out_ff;
  assign port_addr_data_bus_oe = bus_oe_ff;
  assign port_acknowledge = ack_ff;
  assign dsp_rdata = dsp_rdata_ff;
  assign boot_hold = boot_hold_ff;

endmodule // host_memory_port

`default_nettype wire

// ### shared/host_port_consts.svh
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH

// ****************************************************************
// Processor data-space locations of the port control registers
// ****************************************************************
`define HP_START_ADDR_LOC 14'h3fe0
`define HP_OVERLAY_LOC 14'h3fe7

// ****************************************************************
// Bus field positions during an address-latch cycle
// ****************************************************************
`define HP_BUS_OVL_FLAG 15
`define HP_BUS_MEM_SEL 14
`define HP_BUS_ADDR_MSB 13
`define HP_BUS_OVL_MSB 7

// ****************************************************************
// Reset values and boot strap code
// ****************************************************************
`define HP_ADDR_RST 14'h0000
`define HP_OVL_RST 8'h00
`define HP_BOOT_MODE 3'h5
`define HP_BOOT_LOC 14'h0000

// ****************************************************************
// Timing: one cycle of synchronisation, one cycle of memory access
// ****************************************************************
`define HP_SYNC_CYCLES 1
`define HP_MEM_CYCLES 1

`endif

// ### shared/host_port_pkg.sv
package host_port_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_ACCESS = 2'b10,
    ST_DONE = 2'b11
  } port_state_e;

endpackage

// ### shared/mem_port_if.sv
`timescale 1ns/1ps
`default_nettype none

interface mem_port_if;
  logic req;
  logic we;
  logic pm;
  logic [13:0] addr;
  logic [23:0] wdata;
  logic [23:0] rdata;

  modport ctrl (output req, output we, output pm, output addr,
                output wdata, input rdata);
  modport mem (input req, input we, input pm, input addr,
               input wdata, output rdata);
endinterface

`default_nettype wire

// ### design/onchip_memory.sv
`timescale 1ns/1ps
`default_nettype none

module onchip_memory #(
  parameter int DEPTH = 16384
) (
  input wire logic mclk, // System clock.
  mem_port_if.mem mp // Access port from the host port controller.
);

  logic [23:0] prog_mem [DEPTH];
  logic [15:0] data_mem [DEPTH];

  // ****************************************************************
  // Single-cycle access with registered read data
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (mp.req && mp.we && mp.pm) begin
      prog_mem[mp.addr] <= mp.wdata;
    end
    if (mp.req && mp.we && !mp.pm) begin
      data_mem[mp.addr] <= mp.wdata[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (mp.req && !mp.we) begin
      mp.rdata <= mp.pm ? prog_mem[mp.addr] : {8'h00, data_mem[mp.addr]};
    end
  end

endmodule // onchip_memory

`default_nettype wire

// ### verification/host_memory_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "host_port_consts.svh"
// ****************************************************************
// Port timing and register checks
// ****************************************************************
module host_memory_port_asserts (
  input wire logic mclk, // Clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic port_select_n, // Select.
  input wire logic port_address_latch, // Latch strobe.
  input wire logic port_read_n, // Read strobe.
  input wire logic port_write_n, // Write strobe.
  input wire logic [15:0] port_addr_data_bus_in, // Bus in.
  input wire logic [15:0] port_addr_data_bus_out, // Bus out.
  input wire logic port_addr_data_bus_oe, // Bus enable.
  input wire logic port_acknowledge, // Ready.
  input wire logic [13:0] dsp_addr, // Register address.
  input wire logic dsp_wr, // Register write.
  input wire logic dsp_rd, // Register read.
  input wire logic [15:0] dsp_wdata, // Write data.
  input wire logic [15:0] dsp_rdata, // Read data.
  input wire logic mode_a, // Strap A.
  input wire logic mode_b, // Strap B.
  input wire logic mode_c, // Strap C.
  input wire logic boot_hold // Execution held.
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_start;
    port_acknowledge && !port_select_n && (!port_read_n || !port_write_n)
      && !$past(!port_select_n && (!port_read_n || !port_write_n));
  endsequence
  sequence s_reg_wr;
    dsp_wr && dsp_addr == `HP_START_ADDR_LOC && port_select_n ##1
      dsp_rd && dsp_addr == `HP_START_ADDR_LOC && port_select_n;
  endsequence
  AST_ACK_TIME: assert property (s_start |=> !port_acknowledge [*3] ##1
    port_acknowledge) else $error("ack timing wrong");
  AST_ACK_STAY: assert property (port_acknowledge && port_read_n &&
    port_write_n |=> port_acknowledge) else $error("ack dropped idle");
  AST_OE_READ: assert property (port_addr_data_bus_oe |->
    $past(!port_select_n && !port_read_n)) else $error("oe without read");
  AST_OE_ACK: assert property ($rose(port_addr_data_bus_oe) |->
    $rose(port_acknowledge)) else $error("read data before ack");
  AST_RST_QUIET: assert property (disable iff (1'b0) !rst_n |->
    !port_acknowledge && !port_addr_data_bus_oe && !boot_hold)
    else $error("outputs active in reset");
  AST_BOOT_RISE: assert property ($rose(boot_hold) |->
    $past(mode_c && !mode_b && mode_a)) else $error("bad boot hold");
  AST_BOOT_FALL: assert property ($fell(boot_hold) |->
    !port_write_n && !port_select_n) else $error("boot released early");
  AST_REG_WR: assert property (s_reg_wr |=> dsp_rdata ==
    {1'b0, $past(dsp_wdata[14:0], 2)}) else $error("address reg wrong");
  AST_RD_ZERO: assert property (dsp_rd && dsp_addr !=
    `HP_START_ADDR_LOC && dsp_addr != `HP_OVERLAY_LOC |=>
    dsp_rdata == 16'h0000) else $error("unmapped read not zero");
endmodule // host_memory_port_asserts

bind host_memory_port host_memory_port_asserts
  host_memory_port_asserts_inst (.*);
`default_nettype wire

// ### verification/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// External host on the multiplexed port
// ****************************************************************
module host_model (
  input wire logic mclk, // Clock.
  input wire logic ack, // Port acknowledge.
  input wire logic [15:0] dev_out, // Device bus drive.
  input wire logic dev_oe, // Device bus enable.
  output logic sel_n, // Select, active low.
  output logic al, // Address latch.
  output logic rd_n, // Read, active low.
  output logic wr_n, // Write, active low.
  output logic [15:0] bus, // Resolved bus level.
  output logic to // A wait ran out.
);
  logic [15:0] drv;
  logic en;
  // A released bus shows the inverse so stale data never passes.
  assign bus = dev_oe ? dev_out : (en ? drv : ~drv);
  initial begin
    {sel_n, al, rd_n, wr_n, en, to} = 6'b101100;
    drv = 16'h0000;
  end
  task latch(input logic [15:0] v);
    int i;
    i = 0;
    while (ack !== 1'b1 && i < 20) begin
      @(posedge mclk);
      i++;
    end
    if (i >= 20) to = 1;
    @(posedge mclk);
    #1 sel_n = 0;
    al = 1;
    drv = v;
    en = 1;
    @(posedge mclk);
    #1 al = 0;
    @(posedge mclk);
    #1 sel_n = 1;
    en = 0;
  endtask
  task xfer(input logic w, input logic [15:0] v, output logic [15:0] r);
    int i;
    i = 0;
    while (ack !== 1'b1 && i < 20) begin
      @(posedge mclk);
      i++;
    end
    if (i >= 20) to = 1;
    @(posedge mclk);
    #1 drv = v;
    en = w;
    sel_n = 0;
    wr_n = !w;
    rd_n = w;
    i = 0;
    do begin
      @(posedge mclk);
      #1 i++;
    end while ((ack !== 1'b1 || i < 2) && i < 20);
    // Taken from the resolved bus, so a missing enable shows as garbage.
    r = bus;
    {sel_n, rd_n, wr_n, en} = 4'b1110;
    if (i >= 20) to = 1;
    @(posedge mclk);
  endtask
endmodule // host_model
`default_nettype wire

// ### verification/test_host_memory_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "host_port_consts.svh"
// ****************************************************************
// Host port scenarios
// ****************************************************************
module test_host_memory_port;
  logic mclk, rst_n, sel_n, al, rd_n, wr_n, oe, ack, bh, to, dwr, drd;
  logic [15:0] bus, dout, rdat, wdat, r;
  logic [13:0] addr;
  logic ma, mb, mc;
  int n_errors, cmp_count;
  host_memory_port host_memory_port_inst (.mclk(mclk), .rst_n(rst_n),
    .port_select_n(sel_n), .port_address_latch(al), .port_read_n(rd_n),
    .port_write_n(wr_n), .port_addr_data_bus_in(bus),
    .port_addr_data_bus_out(dout), .port_addr_data_bus_oe(oe),
    .port_acknowledge(ack), .dsp_addr(addr), .dsp_wr(dwr), .dsp_rd(drd),
    .dsp_wdata(wdat), .dsp_rdata(rdat), .mode_a(ma), .mode_b(mb),
    .mode_c(mc), .boot_hold(bh));
  host_model host_model_inst (.mclk(mclk), .ack(ack), .dev_out(dout),
    .dev_oe(oe), .sel_n(sel_n), .al(al), .rd_n(rd_n), .wr_n(wr_n),
    .bus(bus), .to(to));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // A write is always followed by a read, which lowers the strobe.
  task reg_wr(input logic [13:0] a, input logic [15:0] d);
    @(posedge mclk);
    #1 addr = a;
    wdat = d;
    dwr = 1;
  endtask
  task reg_rd(input logic [13:0] a, input logic [15:0] e);
    @(posedge mclk);
    #1 dwr = 0;
    addr = a;
    drd = 1;
    @(posedge mclk);
    #1 drd = 0;
    check(rdat, e);
  endtask
  task s_reset;
    check(16'(ack), 16'h0001);
    check(16'(bh), 16'h0001);
    reg_rd(`HP_START_ADDR_LOC, 16'h0000);
    reg_rd(14'h0100, 16'h0000);
  endtask
  task s_block;
    host_model_inst.latch(16'h0010);
    for (int k = 0; k < 3; k++) host_model_inst.xfer(1, 16'ha5a0 + 16'(k), r);
    reg_rd(`HP_START_ADDR_LOC, 16'h0013);
    host_model_inst.latch(16'h0010);
    for (int k = 0; k < 3; k++) begin
      host_model_inst.xfer(0, 16'h0000, r);
      check(r, 16'ha5a0 + 16'(k));
    end
  endtask
  task s_prog;
    host_model_inst.latch(16'h4000);
    host_model_inst.xfer(1, 16'habcd, r);
    check(16'(bh), 16'h0001);
    host_model_inst.xfer(1, 16'h0012, r);
    check(16'(bh), 16'h0000);
    reg_rd(`HP_START_ADDR_LOC, 16'h4001);
    host_model_inst.latch(16'h4000);
    host_model_inst.xfer(0, 16'h0000, r);
    check(r, 16'habcd);
    host_model_inst.xfer(0, 16'h0000, r);
    check(r, 16'h0012);
  endtask
  task s_ovl;
    host_model_inst.latch(16'h8055);
    reg_rd(`HP_OVERLAY_LOC, 16'h0055);
    reg_rd(`HP_START_ADDR_LOC, 16'h4001);
  endtask
  task s_ctrl;
    host_model_inst.latch(16'h3fe0);
    host_model_inst.xfer(1, 16'h1234, r);
    reg_rd(`HP_START_ADDR_LOC, 16'h3fe1);
    reg_wr(`HP_START_ADDR_LOC, 16'h0011);
    reg_rd(`HP_START_ADDR_LOC, 16'h0011);
    host_model_inst.xfer(0, 16'h0000, r);
    check(r, 16'ha5a1);
  endtask
  // A second reset with other straps must leave execution running.
  task s_strap;
    @(posedge mclk);
    #1 rst_n = 0;
    {mc, mb, ma} = 3'h4;
    @(posedge mclk);
    #1 check(16'(ack), 16'h0000);
    rst_n = 1;
    repeat (2) @(posedge mclk);
    #1 check(16'(bh), 16'h0000);
    check(16'(ack), 16'h0001);
    reg_rd(`HP_START_ADDR_LOC, 16'h0000);
    reg_rd(`HP_OVERLAY_LOC, 16'h0000);
  endtask
  task end_of_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge to) begin
    n_errors++;
    end_of_test;
  end
  initial begin
    {rst_n, dwr, drd, addr, wdat, n_errors, cmp_count} = 0;
    {mc, mb, ma} = 3'h5;
    repeat (12) @(posedge mclk);
    #1 rst_n = 1;
    repeat (2) @(posedge mclk);
    #1 s_reset;
    s_block;
    s_prog;
    s_ovl;
    s_ctrl;
    s_strap;
    end_of_test;
  end
endmodule // test_host_memory_port
`default_nettype wire
